/* File: logic/vecr_regs.sv */
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module vecr_regs
  import vecr_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Encoder timing and video decoder caption loads.
  input wire logic i_field_even,
  input wire logic i_line_blanking,
  input wire logic [9:0] i_line_number,
  input wire logic i_line_start,
  input wire logic i_vdec_cc_we,
  input wire logic [1:0] i_vdec_cc_idx,
  input wire logic [6:0] i_vdec_cc_data,
  // Sync pins.
  input wire logic i_vsync,
  input wire logic i_hsync,
  input wire logic i_int_vsync,
  input wire logic i_int_hsync,
  output logic o_vsync,
  output logic o_hsync,
  output logic o_sync_oe,
  output logic o_vsync_used,
  output logic o_hsync_used,
  // Encoder control.
  output vecr_ctrl_s o_ctrl,
  output logic [1:0] o_cc_field_enable,
  output logic [7:0] o_cc_byte [4],
  output logic [3:0] o_dac_enable
);
  logic [7:0] mode0_q;
  logic [6:0] mode2_q;
  logic [7:0] mode1_q;
  logic [1:0] ccen_q;
  logic [6:0] cc_q [4];
  logic [1:0] ccpend_q;
  logic [3:0] dacen_q;
  logic [4:0] rgbst_q;
  logic [4:0] rgbend_q;
  logic [2:0] dacsel_q;
  logic [7:0] attr0_q;
  logic [7:0] attr1_q;
  logic [7:0] attr2_q;
  logic [21:0] attr_live_q;
  logic [5:0] hofs_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] o_hrdata_d;
  logic [1:0] ccen_next;
  logic [3:0] cc_wr;
  logic line21_q;

  function automatic logic [7:0] odd_parity(input logic [6:0] ch);
    odd_parity = {~(^ch), ch};
  endfunction

  // Bus writes complete without wait states; reads come from flops one cycle later.
  // Only whole-word accesses are expected, so the transfer size is not decoded.
  // Address bits above the register window are ignored and alias onto it.
  wire take = i_hsel && i_hready && i_htrans == VECR_HTRANS_NONSEQ;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  wire wr_now = wr_pend_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= take && i_hwrite;
      wr_addr_q <= i_haddr[11:0];
    end
  end

  function automatic logic hit(input logic [11:0] off);
    hit = wr_now && wr_addr_q == off;
  endfunction

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode0_q <= VECR_RST_MODE0;
      mode2_q <= VECR_RST_MODE2;
      mode1_q <= VECR_RST_MODE1;
      dacen_q <= VECR_RST_DACEN;
      rgbst_q <= VECR_RST_RGBST;
      rgbend_q <= VECR_RST_RGBEND;
      dacsel_q <= 3'h0;
      hofs_q <= VECR_RST_HOFS;
    end else begin
      if (hit(VECR_OFF_MODE0)) mode0_q <= i_hwdata[7:0] & 8'h9C;
      if (hit(VECR_OFF_MODE2)) mode2_q <= i_hwdata[6:0] & 7'h4C;
      if (hit(VECR_OFF_MODE1)) mode1_q <= i_hwdata[7:0] & 8'hBF;
      if (hit(VECR_OFF_DACEN)) dacen_q <= i_hwdata[3:0];
      if (hit(VECR_OFF_RGBST)) rgbst_q <= i_hwdata[4:0];
      if (hit(VECR_OFF_RGBEND)) rgbend_q <= i_hwdata[4:0];
      if (hit(VECR_OFF_DACSEL)) dacsel_q <= i_hwdata[2:0];
      if (hit(VECR_OFF_HOFS)) hofs_q <= i_hwdata[5:0];
    end
  end

  // A write to word 2 commits the staged words 0 and 1 as one atomic attribute.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      attr0_q <= 8'h00;
      attr1_q <= 8'h00;
      attr2_q <= 8'h00;
      attr_live_q <= 22'h000000;
    end else begin
      if (hit(VECR_OFF_ATTR0)) attr0_q <= i_hwdata[7:0];
      if (hit(VECR_OFF_ATTR1)) attr1_q <= i_hwdata[7:0];
      if (hit(VECR_OFF_ATTR2)) begin
        attr2_q <= i_hwdata[7:0];
        attr_live_q <= {i_hwdata[5:0], attr1_q, attr0_q};
      end
    end
  end

  always_comb begin
    ccen_next = ccen_q;
    if (hit(VECR_OFF_CCEN)) begin
      ccen_next = i_hwdata[1:0];
    end
  end

  always_comb begin
    cc_wr = 4'h0;
    if (hit(VECR_OFF_CC0)) cc_wr[0] = 1'b1;
    if (hit(VECR_OFF_CC1)) cc_wr[1] = 1'b1;
    if (hit(VECR_OFF_CC2)) cc_wr[2] = 1'b1;
    if (hit(VECR_OFF_CC3)) cc_wr[3] = 1'b1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ccen_q <= 2'b00;
      line21_q <= 1'b0;
    end else begin
      ccen_q <= ccen_next;
      line21_q <= i_line_start && i_line_number == VECR_CC_LINE;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cc
      // Data of a disabled field is held at zero so a stale caption never reappears.
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || !ccen_q[gi/2]) begin
          cc_q[gi] <= 7'h00;
        end else if (cc_wr[gi]) begin
          cc_q[gi] <= i_hwdata[6:0];
        end else if (i_vdec_cc_we && i_vdec_cc_idx == 2'(gi)) begin
          cc_q[gi] <= i_vdec_cc_data;
        end
      end
      assign o_cc_byte[gi] = ccen_q[gi/2] ? odd_parity(cc_q[gi]) : 8'h00;
    end
    for (gi = 0; gi < 2; gi++) begin : g_pend
      wire loaded = ccen_q[gi] && (cc_wr[2*gi] || cc_wr[2*gi+1] ||
        (i_vdec_cc_we && i_vdec_cc_idx[1] == 1'(gi)));
      wire line_done = line21_q && (i_field_even == 1'(gi));
      // A data load in the line 21 cycle wins so the new character is not dropped.
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          ccpend_q[gi] <= 1'b1;
        end else if (ccen_next[gi] && !ccen_q[gi]) begin
          ccpend_q[gi] <= 1'b0;
        end else if (!ccen_next[gi] && ccen_q[gi]) begin
          ccpend_q[gi] <= 1'b1;
        end else if (loaded) begin
          ccpend_q[gi] <= 1'b1;
        end else if (line_done) begin
          ccpend_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    o_hrdata_d = 32'h00000000;
    if (i_haddr[11:0] == VECR_OFF_MODE0) begin
      o_hrdata_d[7:0] = mode0_q;
    end else if (i_haddr[11:0] == VECR_OFF_MODE2) begin
      o_hrdata_d[6:0] = mode2_q;
    end else if (i_haddr[11:0] == VECR_OFF_CCEN) begin
      o_hrdata_d[1:0] = ccen_q;
    end else if (i_haddr[11:0] == VECR_OFF_CC0) begin
      o_hrdata_d[6:0] = cc_q[0];
    end else if (i_haddr[11:0] == VECR_OFF_CC1) begin
      o_hrdata_d[6:0] = cc_q[1];
    end else if (i_haddr[11:0] == VECR_OFF_CC2) begin
      o_hrdata_d[6:0] = cc_q[2];
    end else if (i_haddr[11:0] == VECR_OFF_CC3) begin
      o_hrdata_d[6:0] = cc_q[3];
    end else if (i_haddr[11:0] == VECR_OFF_MODE1) begin
      o_hrdata_d[7:0] = mode1_q;
    end else if (i_haddr[11:0] == VECR_OFF_DACEN) begin
      o_hrdata_d[3:0] = dacen_q;
    end else if (i_haddr[11:0] == VECR_OFF_RGBST) begin
      o_hrdata_d[4:0] = rgbst_q;
    end else if (i_haddr[11:0] == VECR_OFF_RGBEND) begin
      o_hrdata_d[4:0] = rgbend_q;
    end else if (i_haddr[11:0] == VECR_OFF_DACSEL) begin
      o_hrdata_d[2:0] = dacsel_q;
    end else if (i_haddr[11:0] == VECR_OFF_STATUS) begin
      o_hrdata_d[3:0] = {i_field_even, i_line_blanking, ccpend_q};
    end else if (i_haddr[11:0] == VECR_OFF_ATTR0) begin
      o_hrdata_d[7:0] = attr0_q;
    end else if (i_haddr[11:0] == VECR_OFF_ATTR1) begin
      o_hrdata_d[7:0] = attr1_q;
    end else if (i_haddr[11:0] == VECR_OFF_ATTR2) begin
      o_hrdata_d[7:0] = attr2_q;
    end else if (i_haddr[11:0] == VECR_OFF_HOFS) begin
      o_hrdata_d[5:0] = hofs_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h00000000;
    end else if (take && !i_hwrite) begin
      o_hrdata <= o_hrdata_d;
    end
  end

  always_comb begin
    o_ctrl.force_blanking = mode0_q[VECR_BIT_BLANK];
    o_ctrl.chroma_filter_wide = mode0_q[VECR_BIT_FILT];
    if (!mode0_q[VECR_BIT_BARHI]) begin
      o_ctrl.bars = VECR_BARS_OFF;
    end else if (!mode0_q[VECR_BIT_BARLO]) begin
      o_ctrl.bars = VECR_BARS_75;
    end else begin
      o_ctrl.bars = VECR_BARS_FULL;
    end
    o_ctrl.bars_full_is_95 = mode1_q[VECR_BIT_STDHI:VECR_BIT_STDLO] != VECR_STD_525;
    o_ctrl.monochrome = mode2_q[VECR_BIT_MONO];
    o_ctrl.sync_source_select = mode1_q[VECR_BIT_SYNCSRC];
    o_ctrl.standard = mode1_q[VECR_BIT_STDHI:VECR_BIT_STDLO];
    o_ctrl.burst_suppress = mode1_q[VECR_BIT_BURST];
    o_ctrl.sync_pin_direction = mode1_q[VECR_BIT_SYNCDIR];
    o_ctrl.setup_75 = mode1_q[VECR_BIT_SETUP] && mode1_q[VECR_BIT_STDHI:VECR_BIT_STDLO] == VECR_STD_525;
    o_ctrl.dac_enable = dacen_q;
    o_ctrl.dac_mux_select = dacsel_q[VECR_BIT_MUX];
    o_ctrl.ycbcr_phase = dacsel_q[1:0];
    o_ctrl.rgb_start = rgbst_q;
    o_ctrl.rgb_end = rgbend_q;
    o_ctrl.attribute_insert_enable = attr2_q[VECR_BIT_ATTREN];
    o_ctrl.attribute_word = attr_live_q;
    o_ctrl.active_delay = VECR_TD_BASE + 10'(hofs_q);
  end

  assign o_cc_field_enable = ccen_q;
  assign o_dac_enable = dacen_q;
  assign o_sync_oe = !mode1_q[VECR_BIT_SYNCDIR];
  assign o_vsync = i_int_vsync;
  assign o_hsync = i_int_hsync;
  assign o_vsync_used = o_sync_oe ? i_int_vsync : i_vsync;
  assign o_hsync_used = o_sync_oe ? i_int_hsync : i_hsync;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  AST_BLANK_FOLLOWS: assert property (wr_now && wr_addr_q == VECR_OFF_MODE0 |=>
    o_ctrl.force_blanking == $past(i_hwdata[7])) else $error("blanking bit not stored");
  AST_BARS: assert property (mode0_q[3:2] == 2'b10 |-> o_ctrl.bars == VECR_BARS_75)
    else $error("bar pattern decode wrong");
  AST_CC_ZERO: assert property (!ccen_q[0] |=> cc_q[0] == 7'h00 && cc_q[1] == 7'h00)
    else $error("disabled caption data not zero");
  AST_PARITY: assert property (ccen_q[0] |-> ^o_cc_byte[0] == 1'b1)
    else $error("caption parity not odd");
  AST_SYNC_DIR: assert property (o_sync_oe == !mode1_q[VECR_BIT_SYNCDIR] &&
    (o_sync_oe || (o_vsync_used == i_vsync && o_hsync_used == i_hsync)))
    else $error("sync pin enable wrong");
  AST_SETUP: assert property (o_ctrl.standard != VECR_STD_525 |-> !o_ctrl.setup_75)
    else $error("setup active outside 525 lines");
  AST_CC_ARM: assert property ($rose(ccen_q[0]) |-> !ccpend_q[0])
    else $error("caption flag not cleared on enable");
  AST_ATTR_HOLD: assert property (!hit(VECR_OFF_ATTR2) |=> $stable(attr_live_q))
    else $error("attribute word changed without commit");
  AST_TD: assert property (o_ctrl.active_delay >= VECR_TD_BASE && o_ctrl.active_delay <= 10'd145)
    else $error("active delay out of range");
  AST_STATUS_RD: assert property (take && !i_hwrite && i_haddr[11:0] == VECR_OFF_STATUS |=>
    o_hrdata[31:4] == 28'h0000000) else $error("status reserved bits set");

  // Each control field checked below through AST_DELAY_FOLLOWS must follow the word written to it from the cycle after the write lands.
  AST_FILTER_FOLLOWS: assert property (hit(VECR_OFF_MODE0) |=>
    o_ctrl.chroma_filter_wide == $past(i_hwdata[VECR_BIT_FILT]))
    else $error("filter select not stored");
  AST_MONO_FOLLOWS: assert property (hit(VECR_OFF_MODE2) |=>
    o_ctrl.monochrome == $past(i_hwdata[VECR_BIT_MONO]))
    else $error("monochrome bit not stored");
  AST_CCEN_FOLLOWS: assert property (hit(VECR_OFF_CCEN) |=>
    o_cc_field_enable == $past(i_hwdata[1:0]))
    else $error("caption enables not stored");
  AST_SYNC_SRC: assert property (hit(VECR_OFF_MODE1) |=>
    o_ctrl.sync_source_select == $past(i_hwdata[VECR_BIT_SYNCSRC]))
    else $error("sync source not stored");
  AST_STD_FOLLOWS: assert property (hit(VECR_OFF_MODE1) |=>
    o_ctrl.standard == $past(i_hwdata[VECR_BIT_STDHI:VECR_BIT_STDLO]))
    else $error("standard select not stored");
  AST_BURST_FOLLOWS: assert property (hit(VECR_OFF_MODE1) |=>
    o_ctrl.burst_suppress == $past(i_hwdata[VECR_BIT_BURST]))
    else $error("burst suppress not stored");
  AST_DACEN_FOLLOWS: assert property (hit(VECR_OFF_DACEN) |=>
    o_dac_enable == $past(i_hwdata[3:0]))
    else $error("DAC enables not stored");
  AST_DAC_MUX: assert property (hit(VECR_OFF_DACSEL) |=>
    o_ctrl.dac_mux_select == $past(i_hwdata[VECR_BIT_MUX]) && o_ctrl.ycbcr_phase == $past(i_hwdata[1:0]))
    else $error("DAC input select not stored");
  AST_ATTR_EN: assert property (hit(VECR_OFF_ATTR2) |=>
    o_ctrl.attribute_insert_enable == $past(i_hwdata[VECR_BIT_ATTREN]))
    else $error("attribute insert enable not stored");
  AST_DELAY_FOLLOWS: assert property (hit(VECR_OFF_HOFS) |=>
    o_ctrl.active_delay == VECR_TD_BASE + 10'($past(i_hwdata[5:0])))
    else $error("active delay not following offset");
  AST_CC2_ZERO: assert property (!ccen_q[1] |->
    o_cc_byte[2] == 8'h00 && o_cc_byte[3] == 8'h00)
    else $error("disabled second field caption bytes not zero");
  AST_CC_LINE21: assert property (line21_q && !i_field_even && ccen_q[0] && ccen_next[0] &&
    !cc_wr[0] && !cc_wr[1] && !i_vdec_cc_we |=> !ccpend_q[0])
    else $error("caption flag not cleared on line 21");
  AST_CC_RD_TOP: assert property (take && !i_hwrite && i_haddr[11:0] == VECR_OFF_CC0 |=>
    o_hrdata[31:7] == 25'h0)
    else $error("caption data upper bits set");

  COV_CC_LOAD: cover property (ccen_q[0] ##1 ccpend_q[0] ##[1:50] !ccpend_q[0]);
  COV_ATTR: cover property (hit(VECR_OFF_ATTR2));
  COV_EXT_SYNC: cover property (!o_sync_oe);
  COV_BARS_FULL: cover property (o_ctrl.bars == VECR_BARS_FULL);
  COV_SETUP_525: cover property (o_ctrl.setup_75 && o_ctrl.standard == VECR_STD_525);
endmodule

/* File: logic/vecr_pkg.sv */
package vecr_pkg;
  localparam logic [11:0] VECR_OFF_MODE0 = 12'h000;
  localparam logic [11:0] VECR_OFF_MODE2 = 12'h004;
  localparam logic [11:0] VECR_OFF_CCEN = 12'h008;
  localparam logic [11:0] VECR_OFF_CC0 = 12'h00C;
  localparam logic [11:0] VECR_OFF_CC1 = 12'h010;
  localparam logic [11:0] VECR_OFF_CC2 = 12'h014;
  localparam logic [11:0] VECR_OFF_CC3 = 12'h018;
  localparam logic [11:0] VECR_OFF_MODE1 = 12'h01C;
  localparam logic [11:0] VECR_OFF_DACEN = 12'h020;
  localparam logic [11:0] VECR_OFF_RGBST = 12'h024;
  localparam logic [11:0] VECR_OFF_RGBEND = 12'h028;
  localparam logic [11:0] VECR_OFF_DACSEL = 12'h02C;
  localparam logic [11:0] VECR_OFF_STATUS = 12'h11C;
  localparam logic [11:0] VECR_OFF_ATTR0 = 12'h120;
  localparam logic [11:0] VECR_OFF_ATTR1 = 12'h124;
  localparam logic [11:0] VECR_OFF_ATTR2 = 12'h128;
  localparam logic [11:0] VECR_OFF_HOFS = 12'h130;
  localparam logic [7:0] VECR_RST_MODE0 = 8'h00;
  localparam logic [6:0] VECR_RST_MODE2 = 7'h00;
  localparam logic [7:0] VECR_RST_MODE1 = 8'h08;
  localparam logic [3:0] VECR_RST_DACEN = 4'h0;
  localparam logic [4:0] VECR_RST_RGBST = 5'h08;
  localparam logic [4:0] VECR_RST_RGBEND = 5'h1B;
  localparam logic [5:0] VECR_RST_HOFS = 6'h00;
  localparam int VECR_BIT_BLANK = 7;
  localparam int VECR_BIT_FILT = 4;
  localparam int VECR_BIT_BARHI = 3;
  localparam int VECR_BIT_BARLO = 2;
  localparam int VECR_BIT_MONO = 6;
  localparam int VECR_BIT_SYNCSRC = 5;
  localparam int VECR_BIT_STDHI = 4;
  localparam int VECR_BIT_STDLO = 3;
  localparam int VECR_BIT_BURST = 2;
  localparam int VECR_BIT_SYNCDIR = 1;
  localparam int VECR_BIT_SETUP = 0;
  localparam int VECR_BIT_MUX = 2;
  localparam int VECR_BIT_ATTREN = 7;
  localparam logic [1:0] VECR_STD_525 = 2'b00;
  localparam logic [1:0] VECR_STD_625 = 2'b01;
  localparam logic [1:0] VECR_HTRANS_NONSEQ = 2'b10;
  localparam logic [9:0] VECR_CC_LINE = 10'd21;
  localparam logic [9:0] VECR_TD_BASE = 10'd82;

  typedef enum logic [2:0] {
    VECR_BARS_OFF = 3'b001,
    VECR_BARS_75 = 3'b010,
    VECR_BARS_FULL = 3'b100
  } vecr_bars_e;

  typedef struct packed {
    logic force_blanking;
    logic chroma_filter_wide;
    vecr_bars_e bars;
    logic bars_full_is_95;
    logic monochrome;
    logic sync_source_select;
    logic [1:0] standard;
    logic burst_suppress;
    logic sync_pin_direction;
    logic setup_75;
    logic [3:0] dac_enable;
    logic dac_mux_select;
    logic [1:0] ycbcr_phase;
    logic [4:0] rgb_start;
    logic [4:0] rgb_end;
    logic attribute_insert_enable;
    logic [21:0] attribute_word;
    logic [9:0] active_delay;
  } vecr_ctrl_s;

  typedef struct packed {
    logic [7:0] char0;
    logic [7:0] char1;
    logic enable;
  } vecr_caption_s;
endpackage

/* File: verif/vecr_sync_source.sv */
`timescale 1ns/1ps
module vecr_sync_source (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Device side of the sync pins.
  input wire logic i_sync_oe,
  input wire logic i_dev_vsync,
  input wire logic i_dev_hsync,
  // Resolved pin levels.
  output logic o_vsync_wire,
  output logic o_hsync_wire
);
  logic [3:0] pat_q;
  // The pattern moves every cycle so a stale pin value cannot pass for a live one.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pat_q <= 4'h0;
    end else begin
      pat_q <= pat_q + 4'h1;
    end
  end
  // The external source drives only while the device has turned its pins to inputs.
  assign o_vsync_wire = i_sync_oe ? i_dev_vsync : pat_q[3];
  assign o_hsync_wire = i_sync_oe ? i_dev_hsync : pat_q[0];
endmodule

/* File: verif/test_vecr_regs.sv */
`timescale 1ns/1ps
module test_vecr_regs;
  import vecr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'b00, cc_idx = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic fe = 1'b0, blank = 1'b0, lstart = 1'b0, cc_we = 1'b0, iv = 1'b0, ih = 1'b0;
  logic [9:0] lnum = 10'h0;
  logic [6:0] cc_data = 7'h00;
  logic hready, hresp, vw, hw, ov, oh, oe, vu, hu;
  logic [1:0] ccfe;
  logic [7:0] cc_byte [4];
  logic [3:0] dacen;
  vecr_ctrl_s ctrl;
  int mismatches = 0, n_tests = 0, i;
  vecr_regs i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_field_even(fe), .i_line_blanking(blank),
    .i_line_number(lnum), .i_line_start(lstart), .i_vdec_cc_we(cc_we), .i_vdec_cc_idx(cc_idx),
    .i_vdec_cc_data(cc_data), .i_vsync(vw), .i_hsync(hw), .i_int_vsync(iv), .i_int_hsync(ih),
    .o_vsync(ov), .o_hsync(oh), .o_sync_oe(oe), .o_vsync_used(vu), .o_hsync_used(hu), .o_ctrl(ctrl),
    .o_cc_field_enable(ccfe), .o_cc_byte(cc_byte), .o_dac_enable(dacen));
  vecr_sync_source i_src (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sync_oe(oe), .i_dev_vsync(ov),
    .i_dev_hsync(oh), .o_vsync_wire(vw), .o_hsync_wire(hw));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= VECR_HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic wrrd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    ahb(1'b1, a, d);
    rdchk(a, exp);
  endtask
  initial begin
    #(3000 * 100);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(VECR_OFF_MODE1, 32'h08);
    rdchk(VECR_OFF_MODE0, 32'h00);
    rdchk(VECR_OFF_CCEN, 32'h00);
    rdchk(VECR_OFF_RGBST, 32'h08);
    rdchk(VECR_OFF_RGBEND, 32'h1B);
    rdchk(VECR_OFF_ATTR2, 32'h00);
    chk("sync_oe", 32'h1, oe);
    chk("bars", VECR_BARS_OFF, ctrl.bars);
    chk("standard", VECR_STD_625, ctrl.standard);
    @(posedge clk);
    fe <= 1'b1;
    blank <= 1'b1;
    rdchk(VECR_OFF_STATUS, 32'h0F);
    wrrd(VECR_OFF_STATUS, 32'h0, 32'h0F);
    chk("hresp", 32'h0, hresp);
    wrrd(VECR_OFF_MODE0, 32'hFF, 32'h9C);
    chk("blank", 32'h1, ctrl.force_blanking);
    chk("filter", 32'h1, ctrl.chroma_filter_wide);
    chk("bars full", VECR_BARS_FULL, ctrl.bars);
    chk("bars 95", 32'h1, ctrl.bars_full_is_95);
    wrrd(VECR_OFF_MODE0, 32'h08, 32'h08);
    chk("bars 75", VECR_BARS_75, ctrl.bars);
    wrrd(VECR_OFF_MODE2, 32'hFF, 32'h4C);
    chk("mono", 32'h1, ctrl.monochrome);
    wrrd(VECR_OFF_MODE1, 32'h27, 32'h27);
    chk("ext sync", 32'h1, ctrl.sync_source_select);
    chk("burst", 32'h1, ctrl.burst_suppress);
    chk("setup", 32'h1, ctrl.setup_75);
    chk("std 525", VECR_STD_525, ctrl.standard);
    chk("sync_oe in", 32'h0, oe);
    chk("sync dir", 32'h1, ctrl.sync_pin_direction);
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      chk("vsync used", vw, vu);
      chk("hsync used", hw, hu);
    end
    @(posedge clk);
    iv <= 1'b1;
    wrrd(VECR_OFF_MODE1, 32'h08, 32'h08);
    chk("vsync pin", 32'h1, vw);
    chk("hsync pin", 32'h0, hw);
    chk("vsync used int", 32'h1, vu);
    wrrd(VECR_OFF_CC0, 32'h41, 32'h00);
    ahb(1'b1, VECR_OFF_CCEN, 32'h1);
    rdchk(VECR_OFF_STATUS, 32'h0E);
    wrrd(VECR_OFF_CC0, 32'hC1, 32'h41);
    chk("cc byte0", 32'hC1, cc_byte[0]);
    rdchk(VECR_OFF_STATUS, 32'h0F);
    @(posedge clk);
    cc_we <= 1'b1;
    cc_idx <= 2'd1;
    cc_data <= 7'h07;
    @(posedge clk);
    cc_we <= 1'b0;
    rdchk(VECR_OFF_CC1, 32'h07);
    chk("cc byte1", 32'h07, cc_byte[1]);
    wrrd(VECR_OFF_CC2, 32'h55, 32'h00);
    chk("cc byte2", 32'h00, cc_byte[2]);
    @(posedge clk);
    fe <= 1'b0;
    lnum <= VECR_CC_LINE;
    lstart <= 1'b1;
    @(posedge clk);
    lstart <= 1'b0;
    rdchk(VECR_OFF_STATUS, 32'h06);
    wrrd(VECR_OFF_CCEN, 32'h3, 32'h3);
    chk("cc enables", 32'h3, ccfe);
    rdchk(VECR_OFF_STATUS, 32'h04);
    ahb(1'b1, VECR_OFF_ATTR0, 32'h12);
    ahb(1'b1, VECR_OFF_ATTR1, 32'h34);
    chk("attr idle", 32'h0, ctrl.attribute_word);
    ahb(1'b1, VECR_OFF_ATTR2, 32'h85);
    chk("attr live", {6'h05, 8'h34, 8'h12}, ctrl.attribute_word);
    chk("attr en", 32'h1, ctrl.attribute_insert_enable);
    wrrd(VECR_OFF_DACEN, 32'hF, 32'hF);
    chk("dac en", 32'hF, dacen);
    wrrd(VECR_OFF_DACSEL, 32'h7, 32'h7);
    chk("dac mux", 32'h1, ctrl.dac_mux_select);
    chk("phase", 32'h3, ctrl.ycbcr_phase);
    wrrd(VECR_OFF_HOFS, 32'h3F, 32'h3F);
    chk("delay", VECR_TD_BASE + 10'd63, ctrl.active_delay);
    wrrd(VECR_OFF_RGBST, 32'h08, 32'h08);
    wrrd(VECR_OFF_RGBEND, 32'h1B, 32'h1B);
    chk("rgb start", 32'h08, ctrl.rgb_start);
    chk("rgb end", 32'h1B, ctrl.rgb_end);
    wrrd(12'h200, 32'hFF, 32'h00);
    print_verdict();
  end
endmodule
